//--- core/hia_top.v
// host interrupt aggregator: sticky flags, mask, enable, od/push-pull output
`timescale 1ns/1ps
`include "hia_regs.vh"
module hia_top (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// event sources, level, asynchronous
	input wire swap_event,
	input wire touch_event,
	input wire tag_change_event,
	input wire sound_done_event,
	input wire playback_done_event,
	input wire queue_empty_event,
	input wire queue_flag_event,
	input wire conversion_done_event,
	input wire underrun_event,
	// host interrupt pin, active low
	output reg host_int_n_o,
	output reg host_int_n_oe,
	// local interrupt to software
	output reg irq
);
	wire [`HIA_NUM_SRC-1:0] src_raw;
	wire [`HIA_NUM_SRC-1:0] src_sync;
	wire [`HIA_NUM_SRC-1:0] src_rise;
	reg [`HIA_NUM_SRC-1:0] flags_q;
	reg [`HIA_NUM_SRC-1:0] flags_d;
	reg [`HIA_NUM_SRC-1:0] mask_q;
	reg enable_q;
	reg push_pull_q;
	reg [1:0] stat_q;
	reg [1:0] stat_d;
	reg [1:0] stat_mask_q;
	reg [11:0] awaddr_q;
	reg aw_held_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg w_held_q;
	reg flag_read;
	reg [31:0] rdata_d;
	reg [1:0] rresp_d;
	reg pin_active;
	reg pin_active_q;
	wire wr_go;
	wire rd_go;
	wire [2:0] stat_unused;

	// byte-lane merge for a register of up to 9 bits
	function [8:0] merge9;
		input [8:0] old_v;
		input [31:0] wd;
		input [3:0] ws;
		begin
			merge9[7:0] = ws[0] ? wd[7:0] : old_v[7:0];
			merge9[8] = ws[1] ? wd[8] : old_v[8];
		end
	endfunction

	// fixed bit assignment of the sources
	assign src_raw[`HIA_BIT_SWAP] = swap_event;
	assign src_raw[`HIA_BIT_TOUCH] = touch_event;
	assign src_raw[`HIA_BIT_TAG] = tag_change_event;
	assign src_raw[`HIA_BIT_SOUND] = sound_done_event;
	assign src_raw[`HIA_BIT_PLAYBACK] = playback_done_event;
	assign src_raw[`HIA_BIT_QUEUE_EMPTY] = queue_empty_event;
	assign src_raw[`HIA_BIT_QUEUE_FLAG] = queue_flag_event;
	assign src_raw[`HIA_BIT_CONV_DONE] = conversion_done_event;
	assign src_raw[`HIA_BIT_UNDERRUN] = underrun_event;
	assign stat_unused = 3'h0;

	hia_sync #(.W(`HIA_NUM_SRC)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(src_raw),
		.sync_out(src_sync)
	);

	hia_edge #(.W(`HIA_NUM_SRC)) u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.level_in(src_sync),
		.rise_out(src_rise)
	);

	assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	// read mux; a flag read is the clearing access
	always @* begin
		rdata_d = 32'h0000_0000;
		rresp_d = `HIA_RESP_OKAY;
		flag_read = 1'b0;
		case (s_axi_araddr[11:2])
			`HIA_ADDR_FLAGS >> 2: begin
				rdata_d[`HIA_NUM_SRC-1:0] = flags_q;
				flag_read = rd_go;
			end
			`HIA_ADDR_MASK >> 2: begin
				rdata_d[`HIA_NUM_SRC-1:0] = mask_q;
			end
			`HIA_ADDR_ENABLE >> 2: begin
				rdata_d[0] = enable_q;
			end
			`HIA_ADDR_IO_DRIVE >> 2: begin
				rdata_d[`HIA_BIT_PUSH_PULL] = push_pull_q;
			end
			`HIA_ADDR_STATUS >> 2: begin
				rdata_d[1:0] = stat_q;
			end
			`HIA_ADDR_STAT_MASK >> 2: begin
				rdata_d[1:0] = stat_mask_q;
			end
			default: begin
				rresp_d = `HIA_RESP_SLVERR;
			end
		endcase
	end

	// flags: clear on read, new events win over the clear
	always @* begin
		flags_d = flags_q;
		if (flag_read) begin
			flags_d = {`HIA_NUM_SRC{1'b0}};
		end
		flags_d = flags_d | src_rise;
	end

	// pin pulls low only while enabled and a masked flag stands
	always @* begin
		pin_active = enable_q && |(flags_q & mask_q);
	end

	// software status events, set wins over write-one clear
	always @* begin
		stat_d = stat_q;
		if (wr_go && awaddr_q[11:2] == (`HIA_ADDR_STATUS >> 2) && wstrb_q[0]) begin
			stat_d = stat_d & ~wdata_q[1:0];
		end
		stat_d[`HIA_STAT_RD_CLEARED] = stat_d[`HIA_STAT_RD_CLEARED] | (flag_read && |flags_q);
		stat_d[`HIA_STAT_IRQ_ROSE] = stat_d[`HIA_STAT_IRQ_ROSE] | (pin_active && !pin_active_q);
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= {`HIA_NUM_SRC{1'b0}};
			mask_q <= `HIA_RST_MASK;
			enable_q <= `HIA_RST_ENABLE;
			push_pull_q <= `HIA_RST_IO_DRIVE;
			stat_q <= 2'b00;
			stat_mask_q <= 2'b00;
			pin_active_q <= 1'b0;
			awaddr_q <= 12'h000;
			aw_held_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			w_held_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `HIA_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `HIA_RESP_OKAY;
			host_int_n_o <= 1'b1;
			host_int_n_oe <= 1'b0;
			irq <= 1'b0;
		end else begin
			flags_q <= flags_d;
			stat_q <= stat_d;
			pin_active_q <= pin_active;
			// write address and data, taken in either order
			// no new address while a write response is still pending
			s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
				aw_held_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			s_axi_wready <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_held_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `HIA_RESP_OKAY;
				case (awaddr_q[11:2])
					`HIA_ADDR_FLAGS >> 2: begin
					end
					`HIA_ADDR_MASK >> 2: begin
						mask_q <= merge9(mask_q, wdata_q, wstrb_q);
					end
					`HIA_ADDR_ENABLE >> 2: begin
						if (wstrb_q[0]) begin
							enable_q <= wdata_q[0];
						end
					end
					`HIA_ADDR_IO_DRIVE >> 2: begin
						if (wstrb_q[0]) begin
							push_pull_q <= wdata_q[`HIA_BIT_PUSH_PULL];
						end
					end
					`HIA_ADDR_STATUS >> 2: begin
					end
					`HIA_ADDR_STAT_MASK >> 2: begin
						if (wstrb_q[0]) begin
							stat_mask_q <= wdata_q[1:0];
						end
					end
					default: begin
						s_axi_bresp <= `HIA_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// read channel
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (rd_go) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdata_d;
				s_axi_rresp <= rresp_d;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			// open drain: oe only when pulling low; push-pull: driven whenever enabled
			host_int_n_o <= !pin_active;
			if (enable_q && push_pull_q) begin
				host_int_n_oe <= 1'b1;
			end else begin
				host_int_n_oe <= pin_active;
			end
			irq <= |(stat_d & stat_mask_q);
		end
	end
endmodule // hia_top

//--- common/hia_regs.vh
// register map, field positions and reset values of the interrupt aggregator
`ifndef HIA_REGS_VH
`define HIA_REGS_VH
`define HIA_NUM_SRC 9
`define HIA_ADDR_FLAGS 12'h000
`define HIA_ADDR_MASK 12'h004
`define HIA_ADDR_ENABLE 12'h008
`define HIA_ADDR_IO_DRIVE 12'h00C
`define HIA_ADDR_STATUS 12'h010
`define HIA_ADDR_STAT_MASK 12'h014
`define HIA_BIT_SWAP 0
`define HIA_BIT_TOUCH 1
`define HIA_BIT_TAG 2
`define HIA_BIT_SOUND 3
`define HIA_BIT_PLAYBACK 4
`define HIA_BIT_QUEUE_EMPTY 5
`define HIA_BIT_QUEUE_FLAG 6
`define HIA_BIT_CONV_DONE 7
`define HIA_BIT_UNDERRUN 8
`define HIA_BIT_PUSH_PULL 0
`define HIA_RST_MASK 9'h1FF
`define HIA_RST_ENABLE 1'b0
`define HIA_RST_IO_DRIVE 1'b0
`define HIA_STAT_RD_CLEARED 0
`define HIA_STAT_IRQ_ROSE 1
`define HIA_RESP_OKAY 2'b00
`define HIA_RESP_SLVERR 2'b10
`endif

//--- core/hia_sync.v
// two-flop synchroniser for the event source inputs
`timescale 1ns/1ps
module hia_sync #(
	parameter W = 9
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// data
	input wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
	assign sync_out = sync_q;
endmodule // hia_sync

//--- core/hia_edge.v
// rising-edge detector: one-cycle pulse per source level rising
`timescale 1ns/1ps
module hia_edge #(
	parameter W = 9
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// data
	input wire [W-1:0] level_in,
	output wire [W-1:0] rise_out
);
	reg [W-1:0] prev_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			prev_q <= {W{1'b0}};
		end else begin
			prev_q <= level_in;
		end
	end
	assign rise_out = level_in & ~prev_q;
endmodule // hia_edge

//--- verification/hia_host_pin.sv
// host side of the interrupt pin: pull-up resistor on the wire
`timescale 1ns/1ps
module hia_host_pin (
	// pin from the block
	input wire logic host_int_n_o,
	input wire logic host_int_n_oe,
	// level seen by the host
	output wire logic int_n
);
	assign int_n = host_int_n_oe ? host_int_n_o : 1'b1;
endmodule // hia_host_pin

//--- verification/hia_chk.sv
// bus and reset assertions on the aggregator ports
`timescale 1ns/1ps
module hia_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt outputs
	input wire logic host_int_n_oe,
	input wire logic irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_RST_OUT: assert property ($rose(aresetn) |-> !host_int_n_oe && !irq)
		else $error("outputs active after reset");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	AST_B_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_ERR0: assert property (s_axi_rvalid && s_axi_rresp[1] |-> s_axi_rdata == 0)
		else $error("error read returned data");
endmodule // hia_chk
bind hia_top hia_chk chk_u (.*);

//--- verification/tb.sv
// self-checking bench of the interrupt aggregator
`timescale 1ns/1ps
`include "hia_regs.vh"
module tb;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, host_int_n_o, host_int_n_oe, irq;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [8:0] ev = 0;
	wire int_n, swap_event, touch_event, tag_change_event, sound_done_event;
	wire playback_done_event, queue_empty_event, queue_flag_event, conversion_done_event;
	wire underrun_event;
	int bad_count = 0, samples_checked = 0;
	assign {underrun_event, conversion_done_event, queue_flag_event, queue_empty_event,
		playback_done_event, sound_done_event, tag_change_event, touch_event, swap_event} = ev;
	hia_top dut_u (.*);
	hia_host_pin pin_u (.host_int_n_o, .host_int_n_oe, .int_n);
	always #5 aclk = ~aclk;
	task chk(input [31:0] s, input [31:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task wr(input [11:0] a, input [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		repeat (2) @(posedge aclk);
	endtask
	task rd(input [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
	endtask
	task pulse(input int i);
		@(posedge aclk) ev[i] <= 1;
		repeat (2) @(posedge aclk);
		ev[i] <= 0;
		repeat (4) @(posedge aclk);
	endtask
	task t_reset;
		chk(host_int_n_oe, 0);
		rd(`HIA_ADDR_MASK); chk(d, 32'h0000_01ff);
		rd(`HIA_ADDR_IO_DRIVE); chk(d, 32'h0000_0000);
		$display("reset test done");
	endtask
	task t_flags;
		for (int i = 0; i < 9; i++) begin
			pulse(i);
			rd(`HIA_ADDR_FLAGS); chk(d, 32'h0000_0001 << i);
			rd(`HIA_ADDR_FLAGS); chk(d, 32'h0000_0000);
			chk(int_n, 1);
		end
		$display("flag test done");
	endtask
	task t_pin;
		wr(`HIA_ADDR_ENABLE, 1); wr(`HIA_ADDR_MASK, 32'h0000_01fe);
		pulse(0); chk(int_n, 1);
		pulse(1); chk(int_n, 0);
		rd(`HIA_ADDR_FLAGS); chk(d, 32'h0000_0003);
		repeat (3) @(posedge aclk); chk(int_n, 1);
		wr(`HIA_ADDR_IO_DRIVE, 1); chk({host_int_n_oe, int_n}, 2'b11);
		wr(`HIA_ADDR_ENABLE, 0); chk(host_int_n_oe, 0);
		wr(`HIA_ADDR_IO_DRIVE, 0); wr(`HIA_ADDR_MASK, 32'h0000_01ff);
		$display("pin test done");
	endtask
	task t_irq;
		wr(`HIA_ADDR_STAT_MASK, 1); pulse(2);
		rd(`HIA_ADDR_FLAGS); chk(d, 32'h0000_0004);
		repeat (3) @(posedge aclk); chk(irq, 1);
		wr(`HIA_ADDR_STATUS, 1); chk(irq, 0);
		rd(12'h040); chk({r, d}, {`HIA_RESP_SLVERR, 32'h0000_0000});
		$display("irq test done");
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		t_reset; t_flags; t_pin; t_irq;
		tally_and_finish;
	end
	initial begin
		#100us;
		bad_count++;
		tally_and_finish;
	end
endmodule // tb
